// ---- verilog/tppo_defs.vh ----
`ifndef TPPO_DEFS_VH
`define TPPO_DEFS_VH
// Register byte offsets
`define TPPO_OFF_CTRL       8'h00
`define TPPO_OFF_FREQ       8'h04
`define TPPO_OFF_DIR        8'h08
`define TPPO_OFF_TGT_LO     8'h0C
`define TPPO_OFF_TGT_HI     8'h10
`define TPPO_OFF_CNT_LO     8'h14
`define TPPO_OFF_CNT_HI     8'h18
`define TPPO_OFF_STATUS     8'h1C
`define TPPO_OFF_IRQ_STAT   8'h20
`define TPPO_OFF_IRQ_MASK   8'h24
// Control fields
`define TPPO_CTRL_EN        0
`define TPPO_CTRL_CONT      1
`define TPPO_CTRL_RUN       2
`define TPPO_CTRL_SPP       3
// Status fields
`define TPPO_ST_REACHED     0
`define TPPO_ST_OWNED       1
`define TPPO_ST_REFUSED     2
// Interrupt fields
`define TPPO_IRQ_REACHED    0
`define TPPO_IRQ_REFUSED    1
// Direction modes
`define TPPO_MODE_A_LEADS   16'h0001
`define TPPO_MODE_B_LEADS   16'h0002
// Frequency range in Hz
`define TPPO_FREQ_MIN_HZ    16'h000C
`define TPPO_FREQ_MAX_HZ    16'h4E20
// Clock and timing
`define TPPO_CLK_HZ         50000000
`define TPPO_SCAN_US        1000
`define TPPO_SCAN_CYCLES    ((`TPPO_CLK_HZ / 1000000) * `TPPO_SCAN_US)
// Reset values
`define TPPO_FREQ_RST       16'h03E8
`endif

// ---- verilog/tppo_top.v ----
// How it works
// RULE1: Pulses are generated only while the output enable bit is set; clearing it stops them.
// RULE2: With continuous output selected, pulses continue past the target count.
// RULE3: Frequency register gives one full A/B period per second count, clamped to 12 Hz..20 kHz.
// RULE4: Target count is 32 bits held in a low and a high 16-bit word.
// RULE5: Present count is reported as 32 bits in a low and a high word.
// RULE6: Mode one makes phase A lead B, mode two makes phase B lead A.
// RULE7: Every transition on either phase adds one to the present count.
// RULE8: Outside continuous mode, reaching the target sets the reached flag, which clears only when enable turns off.
// RULE9: Software changes frequency, target and mode only while enabled and not yet reached.
// RULE10: Frequency or target change keeps the count; a mode change zeroes it.
// RULE11: The reported count is refreshed once per scan period.
// RULE12: Count zeroes when enable turns on and holds its value when enable turns off.
// RULE13: Works only in run mode and is refused if the single-phase pulse function owns the output.
// RULE14: In non-continuous mode both phases stop changing once the target is reached.
// RULE15: A and B are offset by a quarter period so the four edges are evenly spaced.
`include "tppo_defs.vh"
module tppo_top #(
    parameter SCAN_CYCLES = `TPPO_SCAN_CYCLES,
    parameter CLK_HZ      = `TPPO_CLK_HZ
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         phase_a,
    output reg         phase_b,
    output reg         irq
);
    // Control and setting registers
    reg        en_q;
    reg        cont_q;
    reg        run_q;
    reg        spp_q;
    reg [15:0] freq_q;
    reg [15:0] mode_q;
    reg [15:0] tgt_lo_q;
    reg [15:0] tgt_hi_q;
    reg [31:0] cnt_q;
    reg [31:0] cnt_rep_q;
    reg        reached_q;
    reg        owned_q;
    reg        refused_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg        en_prev_q;
    reg [31:0] scan_q;
    reg [31:0] tick_q;
    reg [1:0]  quad_q;
    reg [31:0] quarter_q;
    // Write channel holding
    reg [31:0] aw_addr_q;
    reg        aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        w_have_q;

    wire [31:0] target     = {tgt_hi_q, tgt_lo_q}; // RULE4
    wire        active     = en_q & run_q & owned_q; // RULE13
    // Settings change only while enabled and not yet reached
    wire        settable   = en_q & ~reached_q; // RULE9
    // Out-of-range settings run at the nearest limit
    wire [15:0] freq_clamp = (freq_q < `TPPO_FREQ_MIN_HZ) ? `TPPO_FREQ_MIN_HZ :
                             (freq_q > `TPPO_FREQ_MAX_HZ) ? `TPPO_FREQ_MAX_HZ : freq_q; // RULE3
    // Quarter period in clock cycles
    wire [31:0] quarter_d  = CLK_HZ / ({16'h0000, freq_clamp} * 32'd4); // RULE15
    localparam [31:0] QUARTER_RST = CLK_HZ / (32'd4 * {16'h0000, `TPPO_FREQ_RST});
    wire        stepping   = active & (cont_q | ~reached_q); // RULE1 RULE2 RULE14
    wire        step       = stepping & (tick_q + 32'd1 >= quarter_q);
    // A target of zero is met only after the count wraps
    wire        hit        = step & ~cont_q & (cnt_q + 32'd1 == target);
    wire        do_write   = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire [7:0]  waddr      = aw_addr_q[7:0];
    wire        wr_word    = do_write & (aw_addr_q[31:8] == 24'h000000);
    // Writing the same direction again keeps the count
    wire        mode_wr    = wr_word & (waddr == `TPPO_OFF_DIR) & settable & (w_strb_q[1:0] == 2'b11)
                             & (w_data_q[15:0] != mode_q);
    wire        en_rise    = en_q & ~en_prev_q;
    wire        claim_fail = en_rise & spp_q;

    // Write address and data accepted in either order
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 32'h00000000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end
        else
        begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_word ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_q       <= 1'b0;
            cont_q     <= 1'b0;
            run_q      <= 1'b0;
            spp_q      <= 1'b0;
            freq_q     <= `TPPO_FREQ_RST;
            mode_q     <= `TPPO_MODE_A_LEADS;
            tgt_lo_q   <= 16'h0000;
            tgt_hi_q   <= 16'h0000;
            irq_mask_q <= 2'b00;
        end
        else if (wr_word)
        begin
            case (waddr)
                `TPPO_OFF_CTRL:
                begin
                    if (w_strb_q[0])
                    begin
                        en_q   <= w_data_q[`TPPO_CTRL_EN];
                        cont_q <= w_data_q[`TPPO_CTRL_CONT];
                        run_q  <= w_data_q[`TPPO_CTRL_RUN];
                        spp_q  <= w_data_q[`TPPO_CTRL_SPP];
                    end
                end
                `TPPO_OFF_FREQ:
                begin
                    if (settable)
                    begin
                        if (w_strb_q[0]) freq_q[7:0]  <= w_data_q[7:0]; // RULE9
                        if (w_strb_q[1]) freq_q[15:8] <= w_data_q[15:8];
                    end
                end
                `TPPO_OFF_DIR:
                begin
                    if (mode_wr)
                        mode_q <= w_data_q[15:0]; // RULE9
                end
                `TPPO_OFF_TGT_LO:
                begin
                    if (settable)
                    begin
                        if (w_strb_q[0]) tgt_lo_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) tgt_lo_q[15:8] <= w_data_q[15:8];
                    end
                end
                `TPPO_OFF_TGT_HI:
                begin
                    if (settable)
                    begin
                        if (w_strb_q[0]) tgt_hi_q[7:0]  <= w_data_q[7:0];
                        if (w_strb_q[1]) tgt_hi_q[15:8] <= w_data_q[15:8];
                    end
                end
                `TPPO_OFF_IRQ_MASK:
                begin
                    if (w_strb_q[0])
                        irq_mask_q <= w_data_q[1:0];
                end
                default:
                begin
                    irq_mask_q <= irq_mask_q;
                end
            endcase
        end
    end

    // Pulse engine, count and flags
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_prev_q <= 1'b0;
            owned_q   <= 1'b0;
            refused_q <= 1'b0;
            reached_q <= 1'b0;
            cnt_q     <= 32'h00000000;
            tick_q    <= 32'h00000000;
            quad_q    <= 2'b00;
        end
        else
        begin
            en_prev_q <= en_q;
            // Disable stops stepping and clears the reached flag
            if (!en_q)
            begin
                owned_q   <= 1'b0;
                reached_q <= 1'b0; // RULE8
                tick_q    <= 32'h00000000;
            end
            else if (en_rise)
            begin
                // Ownership settles once, at the enable rise
                owned_q   <= ~spp_q; // RULE13
                refused_q <= spp_q;
                cnt_q     <= 32'h00000000; // RULE12
                // Phase position is kept so a restart never moves both outputs
                tick_q    <= 32'h00000000;
            end
            else
            begin
                if (mode_wr)
                    cnt_q <= 32'h00000000; // RULE10
                else if (step)
                    cnt_q <= cnt_q + 32'd1; // RULE7
                if (step)
                begin
                    tick_q <= 32'h00000000;
                    if (mode_q == `TPPO_MODE_B_LEADS)
                        quad_q <= quad_q - 2'd1; // RULE6
                    else
                        quad_q <= quad_q + 2'd1; // RULE6
                end
                else if (stepping)
                    tick_q <= tick_q + 32'd1;
                if (hit)
                    reached_q <= 1'b1; // RULE8
            end
        end
    end

    // Scan period refresh of reported count
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scan_q    <= 32'h00000000;
            cnt_rep_q <= 32'h00000000;
        end
        else if (scan_q + 32'd1 >= SCAN_CYCLES)
        begin
            scan_q    <= 32'h00000000;
            cnt_rep_q <= cnt_q; // RULE11 RULE5
        end
        else
            scan_q <= scan_q + 32'd1;
    end

    // Quarter period registered to keep the divider off the step compare path
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            quarter_q <= QUARTER_RST;
        else
            quarter_q <= quarter_d;
    end

    // Fixed gray mapping; direction only reverses the step order
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_a <= 1'b0;
            phase_b <= 1'b0;
        end
        else
        begin
            phase_a <= quad_q[1] ^ quad_q[0]; // RULE6 RULE15
            phase_b <= quad_q[1];
        end
    end

    // Interrupt status, write one to clear, set wins
    wire [1:0] irq_set = {claim_fail, hit};
    wire       irq_wr  = wr_word & (waddr == `TPPO_OFF_IRQ_STAT) & w_strb_q[0];
    genvar     gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_irq
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    irq_stat_q[gi] <= 1'b0;
                else if (irq_set[gi])
                    irq_stat_q[gi] <= 1'b1;
                else if (irq_wr & w_data_q[gi])
                    irq_stat_q[gi] <= 1'b0;
            end
        end
    endgenerate

    // Level interrupt from unmasked sticky bits
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_mask_q);
    end

    // Read channel
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                s_axi_rdata  <= 32'h00000000;
                if (s_axi_araddr[31:8] != 24'h000000)
                    s_axi_rresp <= 2'b10;
                else
                case (s_axi_araddr[7:0])
                    `TPPO_OFF_CTRL:     s_axi_rdata <= {28'h0000000, spp_q, run_q, cont_q, en_q};
                    `TPPO_OFF_FREQ:     s_axi_rdata <= {16'h0000, freq_q};
                    `TPPO_OFF_DIR:      s_axi_rdata <= {16'h0000, mode_q};
                    `TPPO_OFF_TGT_LO:   s_axi_rdata <= {16'h0000, tgt_lo_q};
                    `TPPO_OFF_TGT_HI:   s_axi_rdata <= {16'h0000, tgt_hi_q};
                    // Both count halves come from one snapshot between refreshes
                    `TPPO_OFF_CNT_LO:   s_axi_rdata <= {16'h0000, cnt_rep_q[15:0]}; // RULE5
                    `TPPO_OFF_CNT_HI:   s_axi_rdata <= {16'h0000, cnt_rep_q[31:16]};
                    `TPPO_OFF_STATUS:   s_axi_rdata <= {29'h00000000, refused_q, owned_q, reached_q};
                    `TPPO_OFF_IRQ_STAT: s_axi_rdata <= {30'h00000000, irq_stat_q};
                    `TPPO_OFF_IRQ_MASK: s_axi_rdata <= {30'h00000000, irq_mask_q};
                    default:            s_axi_rresp <= 2'b10;
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- sim/tppo_drive_model.sv ----
module tppo_drive_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        phase_a,
    input  wire logic        phase_b,
    output logic      [31:0] steps,
    output logic      [31:0] fwd,
    output logic      [31:0] rev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a_q;
    logic b_q;
    // Counts every quadrature step and sorts it by the phase that leads
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {steps, fwd, rev, a_q, b_q} <= '0;
        end
        else
        begin
            a_q <= phase_a;
            b_q <= phase_b;
            if (phase_a != a_q || phase_b != b_q)
            begin
                steps <= steps + 32'h1;
                if ((phase_a != a_q && phase_a != phase_b) || (phase_b != b_q && phase_a == phase_b))
                    fwd <= fwd + 32'h1;
                else
                    rev <= rev + 32'h1;
            end
        end
    end
endmodule

// ---- sim/tppo_top_monitor.sv ----
module tppo_top_monitor (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        phase_a,
    input wire logic        phase_b
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
        else $error("wready longer than one cycle");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_one_phase: assert property (!($changed(phase_a) && $changed(phase_b)))
        else $error("both phases moved together");
    // Fastest allowed rate still leaves five cycles per quarter at the bench clock setting
    chk_step_gap: assert property (($changed(phase_a) || $changed(phase_b))
        |=> !($changed(phase_a) || $changed(phase_b))[*4]) else $error("quarter period too short");
endmodule
bind tppo_top tppo_top_monitor u_mon (.clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .phase_a, .phase_b);

// ---- sim/two_phase_pulse_output_test.sv ----
module two_phase_pulse_output_test;
    timeunit 1ns;
    timeprecision 1ps;
`include "tppo_defs.vh"
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   phase_a, phase_b, irq;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata, steps, fwd, rev;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [31:0] d, base;
    logic [1:0]  r;

    tppo_top #(.SCAN_CYCLES(16), .CLK_HZ(400000)) u_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .phase_a, .phase_b, .irq);
    tppo_drive_model u_drive (.clk, .arst_n, .phase_a, .phase_b, .steps, .fwd, .rev);

    always #10 clk = ~clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        $display("mismatches=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge clk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 100)
        begin
            fail_count++;
            end_of_test;
        end
    endtask

    task rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 100)
        begin
            fail_count++;
            end_of_test;
        end
    endtask

    task chk_bits(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        rd(a);
        check(d & m, exp);
    endtask

    // Waits until the selected drive counter reaches a level, or gives up
    task wait_for(input logic use_rev, input logic [31:0] lvl);
        int n;
        for (n = 0; n < 2000 && (use_rev ? rev : steps) < lvl; n++)
            @(posedge clk);
        if (n == 2000)
        begin
            fail_count++;
            end_of_test;
        end
    endtask

    task s_reset_vals;
        chk_bits(`TPPO_OFF_FREQ, 32'hFFFF, 32'h3E8);
        chk_bits(`TPPO_OFF_DIR, 32'hFFFF, 32'h1);
        chk_bits(`TPPO_OFF_CNT_LO, 32'hFFFF, 32'h0);
        check({29'h0, phase_a, phase_b, irq}, 32'h0);
    endtask

    task s_target_stop;
        wr(`TPPO_OFF_CTRL, 32'h4);
        wr(`TPPO_OFF_IRQ_MASK, 32'h1);
        base = steps;
        wr(`TPPO_OFF_CTRL, 32'h5);
        wr(`TPPO_OFF_FREQ, 32'hFA0);
        wr(`TPPO_OFF_TGT_LO, 32'h8);
        wr(`TPPO_OFF_TGT_HI, 32'h0);
        wait_for(1'b0, base + 32'h8);
        chk_bits(`TPPO_OFF_STATUS, 32'h1, 32'h1);
        repeat (60) @(posedge clk);
        check(steps - base, 32'h8);
        check(fwd, 32'h8);
        chk_bits(`TPPO_OFF_CNT_LO, 32'hFFFF, 32'h8);
        chk_bits(`TPPO_OFF_CNT_HI, 32'hFFFF, 32'h0);
        chk_bits(`TPPO_OFF_TGT_LO, 32'hFFFF, 32'h8);
        check({31'h0, irq}, 32'h1);
        wr(`TPPO_OFF_IRQ_STAT, 32'h1);
        wr(`TPPO_OFF_CTRL, 32'h4);
        chk_bits(`TPPO_OFF_STATUS, 32'h1, 32'h0);
        check({31'h0, irq}, 32'h0);
        repeat (40) @(posedge clk);
        chk_bits(`TPPO_OFF_CNT_LO, 32'hFFFF, 32'h8);
    endtask

    task s_mode_cont;
        base = steps;
        wr(`TPPO_OFF_CTRL, 32'h7);
        repeat (40) @(posedge clk);
        rd(`TPPO_OFF_CNT_LO);
        check({31'h0, d[15:0] <= steps - base}, 32'h1);
        wait_for(1'b0, base + 32'hC);
        repeat (30) @(posedge clk);
        check({31'h0, steps - base > 32'hC}, 32'h1);
        // Above the top limit the rate clamps to 20 kHz: one step per 5 cycles at this clock
        wr(`TPPO_OFF_FREQ, 32'hFFFF);
        repeat (10) @(posedge clk);
        base = steps;
        repeat (100) @(posedge clk);
        check(steps - base, 32'h14);
        wr(`TPPO_OFF_DIR, `TPPO_MODE_B_LEADS);
        base = steps;
        repeat (40) @(posedge clk);
        rd(`TPPO_OFF_CNT_LO);
        check({31'h0, d[15:0] <= steps - base}, 32'h1);
        wait_for(1'b1, 32'h8);
        check({31'h0, fwd <= base + 32'h2}, 32'h1);
        wr(`TPPO_OFF_CTRL, 32'h4);
    endtask

    task s_refuse;
        // Let steps launched just before the disable reach the drive
        repeat (5) @(posedge clk);
        base = steps;
        wr(`TPPO_OFF_CTRL, 32'h1);
        repeat (100) @(posedge clk);
        check(steps - base, 32'h0);
        wr(`TPPO_OFF_CTRL, 32'hC);
        wr(`TPPO_OFF_CTRL, 32'hD);
        chk_bits(`TPPO_OFF_STATUS, 32'h4, 32'h4);
        repeat (100) @(posedge clk);
        check(steps - base, 32'h0);
        check({31'h0, irq}, 32'h0);
        chk_bits(`TPPO_OFF_IRQ_STAT, 32'h2, 32'h2);
        wr(`TPPO_OFF_IRQ_STAT, 32'h2);
        chk_bits(`TPPO_OFF_IRQ_STAT, 32'h2, 32'h0);
        rd(8'h30);
        check({30'h0, r}, 32'h2);
        wr(`TPPO_OFF_CTRL, 32'h0);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        s_reset_vals;
        s_target_stop;
        s_mode_cont;
        s_refuse;
        end_of_test;
    end
endmodule
